// file: design/rts_pkg.sv
/*
  Shared constants and types of the reset time-out sequencer: register indices and
  bit positions, reset values, oscillator mode codes, timing figures and the state
  encoding. Assumes a 40 MHz system clock and a 31 kHz low-frequency reference.
*/
package rts_pkg;

  // System clock rate and the low-frequency internal clock rate, in hertz.
  localparam int unsigned RTS_CLK_HZ = 40000000;
  localparam int unsigned RTS_LF_HZ = 31000;
  // System clock cycles per low-frequency tick.
  localparam int unsigned RTS_LF_DIV = RTS_CLK_HZ / RTS_LF_HZ;
  // Power-up delay in milliseconds and the matching count of low-frequency ticks.
  localparam int unsigned RTS_POWER_UP_DELAY_TIMER_MS = 64;
  localparam int unsigned RTS_POWER_UP_DELAY_TIMER_TICKS = (RTS_POWER_UP_DELAY_TIMER_MS * RTS_LF_HZ) / 1000;
  // Oscillator start-up wait in oscillator periods.
  localparam int unsigned RTS_OST_PERIODS = 1024;
  // System clock period in nanoseconds.
  localparam int unsigned RTS_CLK_NS = 25;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] RTS_IDX_POWER_CONTROL = 10'h08E;
  localparam logic [9:0] RTS_IDX_CORE_STATUS = 10'h003;

  // Field positions in the power control register.
  localparam int unsigned RTS_PC_BROWNOUT_BIT = 0;
  localparam int unsigned RTS_PC_POWERON_BIT = 1;
  localparam int unsigned RTS_PC_SW_BOR_EN_BIT = 4;
  localparam int unsigned RTS_PC_ULP_WAKE_BIT = 5;
  // Field positions in the core status register.
  localparam int unsigned RTS_ST_POWERDOWN_BIT = 3;
  localparam int unsigned RTS_ST_WDT_EXPIRED_BIT = 4;

  // Values after the bus reset, which is treated as a power-up.
  localparam logic RTS_RST_BROWNOUT_FLAG = 1'b1;
  localparam logic RTS_RST_POWERON_FLAG = 1'b0;
  localparam logic RTS_RST_SW_BOR_EN = 1'b1;
  localparam logic RTS_RST_ULP_WAKE = 1'b0;
  localparam logic RTS_RST_WDT_EXPIRED = 1'b1;
  localparam logic RTS_RST_POWERDOWN = 1'b1;

  // Oscillator mode codes of the three-bit configuration field.
  localparam logic [2:0] RTS_OSC_LP = 3'h0;
  localparam logic [2:0] RTS_OSC_XT = 3'h1;
  localparam logic [2:0] RTS_OSC_HS = 3'h2;
  localparam logic [2:0] RTS_OSC_EC = 3'h3;

  // Brown-out mode codes.
  localparam logic [1:0] RTS_BOR_OFF = 2'h0;
  localparam logic [1:0] RTS_BOR_SOFTWARE = 2'h1;
  localparam logic [1:0] RTS_BOR_AWAKE_ONLY = 2'h2;
  localparam logic [1:0] RTS_BOR_ALWAYS = 2'h3;

  // Static configuration bits, held steady by the fuse logic.
  typedef struct packed {
    logic [2:0] oscMode;                 // Oscillator mode code.
    logic powerUpDelayDisableCfg;        // One disables the power-up delay.
    logic [1:0] brownoutModeSelect;      // Brown-out mode code.
    logic twoSpeedStartup;               // Two-speed start-up enabled.
    logic failSafeMonitor;               // Fail-safe clock monitor enabled.
    logic timer1OscillatorInput;         // Low-power pins serve the timer1 oscillator.
  } rts_cfg_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    RTS_HOLD = 4'b0001,
    RTS_POWER_UP_DELAY_TIMER = 4'b0010,
    RTS_OST = 4'b0100,
    RTS_RUN = 4'b1000
  } rts_state_t;

endpackage : rts_pkg

// file: design/rts_sequencer.sv
/*
  Reset time-out sequencer: power-up delay timer, oscillator start-up counter,
  brown-out policy, reset-cause flags and an APB slave for the two flag registers.
  Assumes detector outputs, the master-clear pin and the oscillator pin come from
  outside the clock domain, and that core and watchdog strobes share clk.
*/
// Function
// - Power-up delay only after power-on or brown-out
// - Delay counts low-frequency clock ticks
// - Chip reset held while delay runs
// - Configuration bit one disables the delay
// - Mode 01 lets software enable brown-out
// - Awake-only mode ignores software, off asleep
// - Mode 00 disables detection, flag undefined
// - Reset after low supply exceeds minimum time
// - Hold until supply good, then delay
// - Brown-out during delay restarts the delay
// - Start-up counter runs after the delay
// - External clock without delay: immediate release
// - Time-outs ignore master clear; release immediate
// - Fast start lets code run during counting
// - Crystal modes wait 1024 oscillator periods; here LP with timer1 pins skips the wait
// - Other modes: delay only, none on wake
// - Reset-cause flags in power control register
// - Brown-out flag cleared by brown-out reset
// - Power-on flag cleared by power-on reset
// - Watchdog and power-down flags per reset cause
`timescale 1ns/1ps
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned LfDiv = RTS_LF_DIV,             // Cycles per low-frequency tick.
  parameter int unsigned PwrtTicks = RTS_POWER_UP_DELAY_TIMER_TICKS,     // Ticks of the power-up delay.
  parameter int unsigned OstPeriods = RTS_OST_PERIODS,   // Oscillator periods to wait.
  parameter int unsigned BrownoutMinDurationNs = 100000  // Least low time for a trip.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rts_cfg_t cfg,
  input wire logic powerOnDetect,
  input wire logic supplyBelowThreshold,
  input wire logic masterClearPin_n,
  input wire logic oscillatorPin,
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  input wire logic wakeEvent,
  input wire logic clearWatchdogStrobe,
  input wire logic sleepStrobe,
  output logic chipReset,
  output logic startupBusy,
  output logic softwareBrownoutEnable,
  output logic ultraLowPowerWakeEnable
);

  // Least low-supply time in cycles, rounded up.
  localparam int unsigned BorMinCycles =
    (BrownoutMinDurationNs + RTS_CLK_NS - 1) / RTS_CLK_NS;

  // Two-stage synchronisers for the asynchronous inputs.
  logic [3:0] syncA_q;         // First stage, read only by the second.
  logic [3:0] syncB_q;         // Second stage, safe to use.
  logic oscPrev_q;             // Previous synced oscillator level for edge detection.
  logic porLevel;              // Power-on detector active.
  logic supplyLow;             // Supply below the brown-out threshold.
  logic mclrLow;               // Master-clear pin held low.
  logic oscLevel;              // Synced oscillator level.

  // Sequencer state and counters.
  rts_state_t state_q;
  logic startedByPorBor_q;     // Current sequence came from power-on or brown-out.
  logic fromWake_q;            // Oscillator wait was entered from sleep wake-up.
  logic [15:0] lfDivCnt_q;     // Divider towards the low-frequency tick.
  logic lfTick;                // One-cycle tick of the low-frequency clock.
  logic [15:0] pwrtCnt_q;      // Power-up delay tick counter.
  logic [15:0] ostCnt_q;       // Oscillator edge counter.
  logic [19:0] borLowCnt_q;    // Cycles the supply has stayed low.
  logic borTrip_q;             // Brown-out reset condition, registered.
  logic borTripPrev_q;         // Previous trip level for event detection.
  logic mclrPrev_q;            // Previous pin level for event detection.
  logic porPrev_q;             // Previous detector level for event detection.

  // Flag registers.
  logic brownoutFlag_q;
  logic powerOnFlag_q;
  logic swBorEnable_q;
  logic ulpWake_q;
  logic wdtExpired_q;
  logic powerdown_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic chipReset_q;
  logic startupBusy_q;

  // Decoded helpers.
  logic borEnabled;
  logic needOst;
  logic pwrtEnabled;
  logic fastStart;
  logic oscEdge;
  logic porEvent;
  logic borEvent;
  logic mclrEvent;
  logic wdtResetEvent;
  logic wdtWakeEvent;
  logic wakeUp;
  logic setupPhase;
  logic accessWrite;
  logic hitPower;
  logic hitStatus;

  // Synchronise the pin-level inputs; nothing else looks at the first stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
      oscPrev_q <= 1'b0;
    end else begin
      syncA_q <= {oscillatorPin, ~masterClearPin_n, supplyBelowThreshold, powerOnDetect};
      syncB_q <= syncA_q;
      oscPrev_q <= syncB_q[3];
    end
  end

  assign porLevel = syncB_q[0];
  assign supplyLow = syncB_q[1];
  assign mclrLow = syncB_q[2];
  assign oscLevel = syncB_q[3];
  assign oscEdge = oscLevel & ~oscPrev_q;

  // Brown-out enable per mode; off mode never trips, so the flag stays as left.
  always_comb begin
    case (cfg.brownoutModeSelect)
      RTS_BOR_OFF: borEnabled = 1'b0;
      RTS_BOR_SOFTWARE: borEnabled = swBorEnable_q;
      RTS_BOR_AWAKE_ONLY: borEnabled = ~sleepActive;
      default: borEnabled = 1'b1;
    endcase
  end

  // Crystal modes need the start-up count, except low-power with timer1 pins.
  assign needOst = ((cfg.oscMode == RTS_OSC_XT) || (cfg.oscMode == RTS_OSC_HS) ||
                    ((cfg.oscMode == RTS_OSC_LP) && !cfg.timer1OscillatorInput));
  assign pwrtEnabled = ~cfg.powerUpDelayDisableCfg;
  assign fastStart = cfg.twoSpeedStartup | cfg.failSafeMonitor;

  // Low-supply persistence filter: short dips are ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      borLowCnt_q <= 20'h00000;
      borTrip_q <= 1'b0;
    end else if (supplyLow && borEnabled) begin
      if (borLowCnt_q < BorMinCycles[19:0]) begin
        borLowCnt_q <= borLowCnt_q + 20'h00001;
      end else begin
        borTrip_q <= 1'b1;
      end
    end else begin
      borLowCnt_q <= 20'h00000;
      borTrip_q <= 1'b0;
    end
  end

  // Event edges from the level conditions.
  always_ff @(posedge clk) begin
    if (rst) begin
      borTripPrev_q <= 1'b0;
      mclrPrev_q <= 1'b0;
      porPrev_q <= 1'b0;
    end else begin
      borTripPrev_q <= borTrip_q;
      mclrPrev_q <= mclrLow;
      porPrev_q <= porLevel;
    end
  end

  assign porEvent = porLevel & ~porPrev_q;
  assign borEvent = borTrip_q & ~borTripPrev_q & ~porLevel;
  assign mclrEvent = mclrLow & ~mclrPrev_q;
  assign wdtResetEvent = watchdogTimeout & ~sleepActive;
  assign wdtWakeEvent = watchdogTimeout & sleepActive;
  assign wakeUp = sleepActive & (wakeEvent | watchdogTimeout);

  // Low-frequency tick divider; it runs free so the tick rate never depends on state.
  always_ff @(posedge clk) begin
    if (rst || lfDivCnt_q == 16'(LfDiv - 1)) begin
      lfDivCnt_q <= 16'h0000;
    end else begin
      lfDivCnt_q <= lfDivCnt_q + 16'h0001;
    end
  end

  assign lfTick = (lfDivCnt_q == 16'(LfDiv - 1));

  // Sequencer: hold, power-up delay, oscillator wait, run.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RTS_HOLD;
      startedByPorBor_q <= 1'b1;
      fromWake_q <= 1'b0;
      pwrtCnt_q <= 16'h0000;
      ostCnt_q <= 16'h0000;
    end else if (porLevel || borTrip_q) begin
      // Any new power-on or brown-out condition reinitialises the timers.
      state_q <= RTS_HOLD;
      startedByPorBor_q <= 1'b1;
      fromWake_q <= 1'b0;
      pwrtCnt_q <= 16'h0000;
      ostCnt_q <= 16'h0000;
    end else begin
      case (state_q)
        RTS_HOLD: begin
          // Leave once the supply is good, when brown-out is enabled.
          if (!(supplyLow && borEnabled)) begin
            pwrtCnt_q <= 16'h0000;
            ostCnt_q <= 16'h0000;
            if (startedByPorBor_q && pwrtEnabled) begin
              state_q <= RTS_POWER_UP_DELAY_TIMER;
            end else if (startedByPorBor_q && needOst) begin
              state_q <= RTS_OST;
            end else begin
              state_q <= RTS_RUN;
            end
          end
        end
        RTS_POWER_UP_DELAY_TIMER: begin
          if (lfTick) begin
            if (pwrtCnt_q == 16'(PwrtTicks - 1)) begin
              state_q <= needOst ? RTS_OST : RTS_RUN;
            end else begin
              pwrtCnt_q <= pwrtCnt_q + 16'h0001;
            end
          end
        end
        RTS_OST: begin
          if (oscEdge) begin
            if (ostCnt_q == 16'(OstPeriods - 1)) begin
              state_q <= RTS_RUN;
              fromWake_q <= 1'b0;
            end else begin
              ostCnt_q <= ostCnt_q + 16'h0001;
            end
          end
        end
        RTS_RUN: begin
          if (wdtResetEvent) begin
            // A watchdog reset takes no time-out of its own.
            state_q <= RTS_HOLD;
            startedByPorBor_q <= 1'b0;
          end else if (wakeUp && needOst) begin
            state_q <= RTS_OST;
            fromWake_q <= 1'b1;
            ostCnt_q <= 16'h0000;
          end
        end
        default: begin
          state_q <= RTS_HOLD;
        end
      endcase
    end
  end

  // Chip reset and start-up busy, registered. The pin only gates the final reset,
  // so the time-outs run on underneath a held pin and release is immediate.
  always_ff @(posedge clk) begin
    if (rst) begin
      chipReset_q <= 1'b1;
      startupBusy_q <= 1'b1;
    end else begin
      chipReset_q <= (state_q == RTS_HOLD) || (state_q == RTS_POWER_UP_DELAY_TIMER) || mclrLow ||
                     ((state_q == RTS_OST) && !fromWake_q && !fastStart);
      startupBusy_q <= (state_q != RTS_RUN);
    end
  end

  // APB phase decode.
  assign setupPhase = psel & ~penable;
  assign accessWrite = psel & penable & pwrite;
  assign hitPower = (paddr == {RTS_IDX_POWER_CONTROL, 2'b00});
  assign hitStatus = (paddr == {RTS_IDX_CORE_STATUS, 2'b00});

  // Power control flags; hardware reset causes win over a write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      brownoutFlag_q <= RTS_RST_BROWNOUT_FLAG;
      powerOnFlag_q <= RTS_RST_POWERON_FLAG;
      swBorEnable_q <= RTS_RST_SW_BOR_EN;
      ulpWake_q <= RTS_RST_ULP_WAKE;
    end else begin
      if (accessWrite && hitPower) begin
        brownoutFlag_q <= pwdata[RTS_PC_BROWNOUT_BIT];
        powerOnFlag_q <= pwdata[RTS_PC_POWERON_BIT];
        swBorEnable_q <= pwdata[RTS_PC_SW_BOR_EN_BIT];
        ulpWake_q <= pwdata[RTS_PC_ULP_WAKE_BIT];
      end
      if (porEvent) begin
        powerOnFlag_q <= 1'b0;
      end
      if (borEvent) begin
        brownoutFlag_q <= 1'b0;
      end
      if (porEvent || borEvent) begin
        swBorEnable_q <= 1'b1;
        ulpWake_q <= 1'b0;
      end else if (wdtResetEvent || mclrEvent) begin
        ulpWake_q <= 1'b0;
      end
    end
  end

  // Watchdog-expired and power-down flags; core strobes first, reset causes override.
  always_ff @(posedge clk) begin
    if (rst) begin
      wdtExpired_q <= RTS_RST_WDT_EXPIRED;
      powerdown_q <= RTS_RST_POWERDOWN;
    end else begin
      if (clearWatchdogStrobe) begin
        wdtExpired_q <= 1'b1;
        powerdown_q <= 1'b1;
      end else if (sleepStrobe) begin
        wdtExpired_q <= 1'b1;
        powerdown_q <= 1'b0;
      end
      if (porEvent || borEvent) begin
        wdtExpired_q <= 1'b1;
        powerdown_q <= 1'b1;
      end else if (wdtWakeEvent) begin
        wdtExpired_q <= 1'b0;
        powerdown_q <= 1'b0;
      end else if (wdtResetEvent) begin
        wdtExpired_q <= 1'b0;
      end else if (mclrEvent && sleepActive) begin
        wdtExpired_q <= 1'b1;
        powerdown_q <= 1'b0;
      end
    end
  end

  // Read data and error latch in the setup cycle for a zero-wait access.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setupPhase) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      if (hitPower) begin
        prdata_q[RTS_PC_BROWNOUT_BIT] <= brownoutFlag_q;
        prdata_q[RTS_PC_POWERON_BIT] <= powerOnFlag_q;
        prdata_q[RTS_PC_SW_BOR_EN_BIT] <= swBorEnable_q;
        prdata_q[RTS_PC_ULP_WAKE_BIT] <= ulpWake_q;
      end else if (hitStatus) begin
        prdata_q[RTS_ST_POWERDOWN_BIT] <= powerdown_q;
        prdata_q[RTS_ST_WDT_EXPIRED_BIT] <= wdtExpired_q;
        // Status is read-only here; a write is refused.
        pslverr_q <= pwrite;
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  // Outputs.
  assign prdata = prdata_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & pslverr_q;
  assign chipReset = chipReset_q;
  assign startupBusy = startupBusy_q;
  assign softwareBrownoutEnable = swBorEnable_q;
  assign ultraLowPowerWakeEnable = ulpWake_q;

endmodule : rts_sequencer

// file: testbench/rts_sequencer_asserts.sv
/* Checker of the sequencer's ports: bus answers, reset hold and release.
   Assumes it is bound to rts_sequencer with the same parameters. */
`timescale 1ns/1ps
module rts_sequencer_asserts
  import rts_pkg::*;
#(
  parameter int unsigned LfDiv = RTS_LF_DIV,
  parameter int unsigned PwrtTicks = RTS_POWER_UP_DELAY_TIMER_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire rts_cfg_t cfg,
  input wire logic powerOnDetect,
  input wire logic supplyBelowThreshold,
  input wire logic masterClearPin_n,
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  input wire logic chipReset,
  input wire logic startupBusy,
  input wire logic softwareBrownoutEnable,
  input wire logic ultraLowPowerWakeEnable
);
  localparam logic [11:0] PcAddr = {RTS_IDX_POWER_CONTROL, 2'b00}; // Byte address.
  localparam logic [11:0] StAddr = {RTS_IDX_CORE_STATUS, 2'b00}; // Byte address.
  int unsigned holdCnt_q; // Reset cycles since the bus reset let go.
  logic fromRst_q; // Until the first release.

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles of chip reset after the bus reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      holdCnt_q <= 0;
      fromRst_q <= 1'b1;
    end else if (!chipReset) begin
      fromRst_q <= 1'b0;
    end else begin
      holdCnt_q <= holdCnt_q + 1;
    end
  end

  sequence s_short_pulse;
    chipReset ##[1:4] !chipReset;
  endsequence
  sequence s_pin_low;
    !masterClearPin_n [*3];
  endsequence

  a_ready_access: assert property (pready == (psel && penable))
    else $error("bad ready");
  a_err_unmapped: assert property (psel && penable && paddr != PcAddr && paddr != StAddr
    |-> pslverr) else $error("unmapped access not refused");
  a_status_write: assert property (psel && penable && pwrite && paddr == StAddr |-> pslverr)
    else $error("status write not refused");
  a_mapped_ok: assert property (psel && penable && paddr == PcAddr |-> !pslverr)
    else $error("mapped access refused");
  a_reset_state: assert property ($fell(rst) |-> chipReset && startupBusy
    && softwareBrownoutEnable && !ultraLowPowerWakeEnable) else $error("bad reset state");
  a_power_up_delay_timer_hold: assert property ($fell(chipReset) && fromRst_q && !cfg.powerUpDelayDisableCfg
    |-> holdCnt_q > (PwrtTicks - 1) * LfDiv) else $error("delay too short");
  a_ec_release: assert property ($fell(rst) && cfg.oscMode == RTS_OSC_EC
    && cfg.powerUpDelayDisableCfg && !powerOnDetect && !supplyBelowThreshold
    && masterClearPin_n |-> ##[1:8] !chipReset) else $error("no fast release");
  a_wdt_release: assert property (watchdogTimeout && !sleepActive && !chipReset
    && !startupBusy && masterClearPin_n && !supplyBelowThreshold && !powerOnDetect
    |-> ##[1:3] s_short_pulse) else $error("watchdog reset not short");
  a_pin_gates: assert property (s_pin_low |=> chipReset)
    else $error("pin low, no reset");
endmodule : rts_sequencer_asserts

bind rts_sequencer rts_sequencer_asserts #(.LfDiv(LfDiv), .PwrtTicks(PwrtTicks))
  rts_sequencer_asserts_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cfg(cfg),
  .powerOnDetect(powerOnDetect), .supplyBelowThreshold(supplyBelowThreshold),
  .masterClearPin_n(masterClearPin_n), .watchdogTimeout(watchdogTimeout),
  .sleepActive(sleepActive), .chipReset(chipReset), .startupBusy(startupBusy),
  .softwareBrownoutEnable(softwareBrownoutEnable),
  .ultraLowPowerWakeEnable(ultraLowPowerWakeEnable));

// file: testbench/rts_detector_model.sv
/* Partner model of the supply detectors, the master-clear pin and the crystal.
   Assumes its task is called just after a rising clock edge. */
`timescale 1ns/1ps
module rts_detector_model (
  input wire logic clk,
  output logic powerOnDetect,
  output logic supplyBelowThreshold,
  output logic masterClearPin_n,
  output logic oscillatorPin
);
  logic [1:0] oscDiv_q; // Slows the crystal so a wait spans many clocks.

  // Supply good, pin released by its pull-up, crystal low.
  initial begin
    powerOnDetect = 1'b0;
    supplyBelowThreshold = 1'b0;
    masterClearPin_n = 1'b1;
    oscillatorPin = 1'b0;
    oscDiv_q = 2'h0;
  end

  // The crystal runs free once powered, a rising edge every eight clocks.
  always @(posedge clk) begin
    oscDiv_q <= oscDiv_q + 2'h1;
    if (oscDiv_q == 2'h3) begin
      oscillatorPin <= !oscillatorPin;
    end
  end

  // Holds one event for n cycles: 0 power-on, 1 supply dip, 2 pin low.
  task automatic hold_event(input int k, input int n);
    @(posedge clk);
    case (k)
      0: powerOnDetect <= 1'b1;
      1: supplyBelowThreshold <= 1'b1;
      default: masterClearPin_n <= 1'b0;
    endcase
    repeat (n) @(posedge clk);
    powerOnDetect <= 1'b0;
    supplyBelowThreshold <= 1'b0;
    masterClearPin_n <= 1'b1;
  endtask : hold_event
endmodule : rts_detector_model

// file: testbench/rts_sequencer_tb.sv
/* Self-checking bench of the reset time-out sequencer with shortened counts.
   Assumes the detector model drives the supply, pin and crystal inputs. */
`timescale 1ns/1ps
module rts_sequencer_tb import rts_pkg::*;;
  localparam logic [11:0] PcAddr = {RTS_IDX_POWER_CONTROL, 2'b00}; // Byte address.
  localparam logic [11:0] StAddr = {RTS_IDX_CORE_STATUS, 2'b00}; // Byte address.
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, sawReset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed, w;
  rts_cfg_t cfg;
  logic powerOnDetect, supplyBelowThreshold, masterClearPin_n, oscillatorPin;
  logic watchdogTimeout, sleepActive, wakeEvent, clearWatchdogStrobe, sleepStrobe;
  logic chipReset, startupBusy, softwareBrownoutEnable, ultraLowPowerWakeEnable;
  int num_errors, total_checks;

  rts_sequencer #(.LfDiv(4), .PwrtTicks(3), .OstPeriods(4), .BrownoutMinDurationNs(100))
    rts_sequencer_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .powerOnDetect(powerOnDetect), .supplyBelowThreshold(supplyBelowThreshold),
    .masterClearPin_n(masterClearPin_n), .oscillatorPin(oscillatorPin),
    .watchdogTimeout(watchdogTimeout), .sleepActive(sleepActive), .wakeEvent(wakeEvent),
    .clearWatchdogStrobe(clearWatchdogStrobe), .sleepStrobe(sleepStrobe),
    .chipReset(chipReset), .startupBusy(startupBusy),
    .softwareBrownoutEnable(softwareBrownoutEnable),
    .ultraLowPowerWakeEnable(ultraLowPowerWakeEnable));
  rts_detector_model rts_detector_model_i (.clk(clk), .powerOnDetect(powerOnDetect),
    .supplyBelowThreshold(supplyBelowThreshold), .masterClearPin_n(masterClearPin_n),
    .oscillatorPin(oscillatorPin));

  always #12.5 clk = ~clk;

  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  // Only the four defined power control bits read back.
  function automatic logic [31:0] pc_of(input logic [31:0] v);
    return v & 32'h33;
  endfunction : pc_of
  function automatic logic [31:0] st_of(input logic to, input logic pd);
    return {27'h0, to, pd, 3'h0};
  endfunction : st_of
  // Whether a long dip must reset the chip in a mode, asleep or not.
  function automatic logic trips(input logic [1:0] m, input logic sb, input logic sl);
    return m == RTS_BOR_ALWAYS || (m == RTS_BOR_SOFTWARE && sb) || (m == RTS_BOR_AWAKE_ONLY && !sl);
  endfunction : trips

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data and error land in rdat and err.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd_chk
  // One-cycle core pulse: 0 watchdog, 1 wake, 2 clear watchdog, 3 sleep.
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: watchdogTimeout <= 1'b1;
      1: wakeEvent <= 1'b1;
      2: clearWatchdogStrobe <= 1'b1;
      default: sleepStrobe <= 1'b1;
    endcase
    @(posedge clk);
    {watchdogTimeout, wakeEvent, clearWatchdogStrobe, sleepStrobe} <= 4'h0;
  endtask : pulse
  // Synchronisers delay busy by a few cycles.
  task automatic wait_run();
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    while ((startupBusy !== 1'b0 || chipReset !== 1'b0) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, chipReset}, 32'h0);
  endtask : wait_run
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // A hang in any wait ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {seed, num_errors, total_checks, clk, rst} = {32'h8F7B, 64'h0, 2'b01};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {watchdogTimeout, sleepActive, wakeEvent, clearWatchdogStrobe, sleepStrobe} = 5'h0;
    cfg = '0;
    cfg.oscMode = RTS_OSC_XT;
    cfg.brownoutModeSelect = RTS_BOR_ALWAYS;
    do_reset();
    wait_run();
    rd_chk(PcAddr, 32'h11);
    rd_chk(StAddr, st_of(1'b1, 1'b1));
    repeat (4) begin
      w = next_rand();
      apb(1'b1, PcAddr, w);
      rd_chk(PcAddr, pc_of(w));
    end
    // Refused: status write and unmapped read.
    apb(1'b1, StAddr, 32'hFF);
    chk({31'h0, err}, 32'h1);
    rd_chk(StAddr, st_of(1'b1, 1'b1));
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    // A second dip lands inside the restarted delay.
    apb(1'b1, PcAddr, 32'h23);
    rts_detector_model_i.hold_event(1, 10);
    repeat (8) @(posedge clk);
    rts_detector_model_i.hold_event(1, 10);
    wait_run();
    rd_chk(PcAddr, 32'h12);
    rd_chk(StAddr, st_of(1'b1, 1'b1));
    apb(1'b1, PcAddr, 32'h23);
    pulse(0);
    wait_run();
    rd_chk(PcAddr, 32'h03);
    rd_chk(StAddr, st_of(1'b0, 1'b1));
    // Sleep, interrupt wake, watchdog wake, then pin resets asleep and awake.
    pulse(3);
    sleepActive <= 1'b1;
    pulse(1);
    wait_run();
    rd_chk(StAddr, st_of(1'b1, 1'b0));
    pulse(0);
    wait_run();
    rd_chk(StAddr, st_of(1'b0, 1'b0));
    rts_detector_model_i.hold_event(2, 6);
    wait_run();
    rd_chk(StAddr, st_of(1'b1, 1'b0));
    sleepActive <= 1'b0;
    pulse(2);
    rts_detector_model_i.hold_event(2, 6);
    wait_run();
    rd_chk(StAddr, st_of(1'b1, 1'b1));
    apb(1'b1, PcAddr, 32'h03);
    rts_detector_model_i.hold_event(0, 6);
    wait_run();
    apb(1'b0, PcAddr, 32'h0);
    chk(rdat & 32'h32, 32'h10);
    // Every brown-out mode, awake and asleep, with a random software enable.
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        w = next_rand();
        cfg.brownoutModeSelect <= m[1:0];
        sleepActive <= s[0];
        apb(1'b1, PcAddr, {27'h0, w[0], 4'h3});
        sawReset = 1'b0;
        rts_detector_model_i.hold_event(1, 10);
        repeat (6) @(posedge clk) sawReset |= chipReset;
        sleepActive <= 1'b0;
        wait_run();
        chk({31'h0, sawReset}, {31'h0, trips(m[1:0], w[0], s[0])});
      end
    end
    // External clock with no delay leaves reset at once.
    cfg.oscMode <= RTS_OSC_EC;
    cfg.powerUpDelayDisableCfg <= 1'b1;
    do_reset();
    repeat (8) @(posedge clk);
    chk({31'h0, chipReset}, 32'h0);
    // Two-speed start lets code run while the crystal count goes on.
    cfg.oscMode <= RTS_OSC_XT;
    cfg.twoSpeedStartup <= 1'b1;
    do_reset();
    repeat (8) @(posedge clk);
    chk({30'h0, startupBusy, chipReset}, 32'h2);
    report_and_stop();
  end
endmodule : rts_sequencer_tb
